// file: rtl/status_led_wake_control_defs.vh
// Constants for the status LED, wake indicator and general-purpose line block.
// Assumes a single 40 MHz clock and a 32-bit Avalon-MM register port.
`ifndef STATUS_LED_WAKE_CONTROL_DEFS_VH
`define STATUS_LED_WAKE_CONTROL_DEFS_VH

// Register byte offsets.
`define OFS_CTRL 5'h00
`define OFS_GPIO_CFG 5'h04
`define OFS_GPIO_DATA 5'h08
`define OFS_IRQ_STATUS 5'h0C
`define OFS_IRQ_MASK 5'h10
`define OFS_BYTE_TEST 5'h14
`define OFS_STATE 5'h18

// Control register fields.
`define CTRL_SOFT_RESET 0
`define CTRL_WAKE_EN 1
`define CTRL_WAKE_POL 2
`define CTRL_WAKE_OD 3
`define CTRL_POWER_SAVE 4

// General-purpose configuration fields, three bits each.
`define CFG_DIR_LSB 0
`define CFG_OD_LSB 4
`define CFG_LED_LSB 8

// Interrupt status bits.
`define IRQ_WAKE 0
`define IRQ_LINK 1
`define IRQ_WOKE 2

// State register fields.
`define ST_XOVER 0
`define ST_POWER_SAVE 1
`define ST_READ_SEEN 2
`define ST_WAKE 3

// Fixed test pattern; the value is arbitrary.
`define BYTE_TEST_VALUE 32'h1234_5678

// Timing.
`define CLK_HZ 40000000
`define BLINK_MS 80
`define BLINK_CNT_W 22
// Blink interval in clock cycles: 80 ms at 40 MHz, sized to the counter.
`define BLINK_CYCLES_DEF 22'h30_D400

// Widths and resets.
`define GPIO_N 3
`define CTRL_RESET 5'h00
`define CFG_RESET 11'h000
`define MASK_RESET 3'h0

`endif

// file: rtl/status_led_wake_control.v
// Status LED, wake indicator, crossover strap and general-purpose line block.
// Assumes clk stands for the 25 MHz-class reference running here at 40 MHz,
// and that all pin and status inputs are synchronous to clk.
`timescale 1ns/1ps
`include "status_led_wake_control_defs.vh"

module status_led_wake_control #(
  parameter [`BLINK_CNT_W-1:0] BLINK_CYCLES = `BLINK_CYCLES_DEF
) (
  // Clock and reset.
  input wire clk,
  input wire reset,
  // Avalon-MM register slave.
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Interrupt.
  output wire irq,
  // Link state from the physical layer.
  input wire link_up,
  input wire speed_10,
  input wire autoneg_busy,
  input wire full_duplex,
  input wire tx_rx_activity,
  input wire wake_event,
  // Crossover strap and result.
  input wire crossover_auto_strap,
  output reg crossover_auto_enable,
  // Power state.
  output wire power_save,
  // Wake indicator pin.
  output reg wake_indicator_out,
  output reg wake_indicator_oe_n,
  // General-purpose lines, shared with the LED functions.
  input wire [`GPIO_N-1:0] gpio_in,
  output reg [`GPIO_N-1:0] gpio_out,
  output reg [`GPIO_N-1:0] gpio_oe_n
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  localparam [1:0] BL_IDLE = 2'b00;
  localparam [1:0] BL_OFF = 2'b01;
  localparam [1:0] BL_HOLD = 2'b10;

  reg ack_ff;
  reg soft_rst_ff;
  reg [4:0] ctrl_ff;
  reg [10:0] cfg_ff;
  reg [`GPIO_N-1:0] gpio_data_ff;
  reg [2:0] irq_status_ff;
  reg [2:0] irq_mask_ff;
  reg read_seen_ff;
  reg power_save_ff;
  reg wake_active_ff;
  reg strap_taken_ff;
  reg link_prev_ff;
  reg [1:0] blink_state_ff;
  reg [1:0] nxt_blink_state;
  reg [`BLINK_CNT_W-1:0] blink_cnt_ff;
  reg [`BLINK_CNT_W-1:0] nxt_blink_cnt;
  reg [31:0] nxt_readdata;
  reg [2:0] irq_set;
  reg [2:0] irq_clr;
  reg [`GPIO_N-1:0] led_n;
  wire req;
  wire take_rd;
  wire take_wr;
  wire wr_ok;
  wire wake_level;
  integer i;

  // ********************************************************************
  // Bus handshake
  // ********************************************************************
  // Every request waits exactly one cycle; it is taken on the edge after.
  assign req = read | write;
  assign waitrequest = req & ~ack_ff;
  assign take_rd = read & ack_ff;
  assign take_wr = write & ack_ff;
  // Writes land only after a read and outside power save.
  assign wr_ok = take_wr & read_seen_ff & ~power_save_ff;
  assign power_save = power_save_ff;

  // Acknowledge flag alternates while a request is held.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end

  // Read data is prepared in the wait cycle and stands while it is taken.
  always @*
  begin
    nxt_readdata = 32'h0000_0000;
    case (address)
      `OFS_CTRL: nxt_readdata[4:0] = ctrl_ff;
      `OFS_GPIO_CFG: nxt_readdata[10:0] = cfg_ff;
      `OFS_GPIO_DATA: nxt_readdata[`GPIO_N-1:0] = gpio_in;
      `OFS_IRQ_STATUS: nxt_readdata[2:0] = irq_status_ff;
      `OFS_IRQ_MASK: nxt_readdata[2:0] = irq_mask_ff;
      `OFS_BYTE_TEST: nxt_readdata = `BYTE_TEST_VALUE;
      `OFS_STATE:
      begin
        nxt_readdata[`ST_XOVER] = crossover_auto_enable;
        nxt_readdata[`ST_POWER_SAVE] = power_save_ff;
        nxt_readdata[`ST_READ_SEEN] = read_seen_ff;
        nxt_readdata[`ST_WAKE] = wake_active_ff;
      end
      default: nxt_readdata = 32'h0000_0000;
    endcase
  end

  // Read data register.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      readdata <= 32'h0000_0000;
    else if (read & ~ack_ff)
      readdata <= nxt_readdata;
  end

  // ********************************************************************
  // Control registers
  // ********************************************************************
  // Soft reset is a one-cycle pulse that clears the registers and the power, wake, interrupt and blink state.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      soft_rst_ff <= 1'b0;
    else
      soft_rst_ff <= wr_ok && address == `OFS_CTRL && writedata[`CTRL_SOFT_RESET];
  end

  // Configuration registers; the soft reset bit itself never stores.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_ff <= `CTRL_RESET;
      cfg_ff <= `CFG_RESET;
      gpio_data_ff <= {`GPIO_N{1'b0}};
      irq_mask_ff <= `MASK_RESET;
    end
    else if (soft_rst_ff)
    begin
      ctrl_ff <= `CTRL_RESET;
      cfg_ff <= `CFG_RESET;
      gpio_data_ff <= {`GPIO_N{1'b0}};
      irq_mask_ff <= `MASK_RESET;
    end
    else if (wr_ok)
    begin
      if (address == `OFS_CTRL)
        ctrl_ff <= {1'b0, writedata[3:1], 1'b0};
      if (address == `OFS_GPIO_CFG)
        cfg_ff <= writedata[10:0];
      if (address == `OFS_GPIO_DATA)
        gpio_data_ff <= writedata[`GPIO_N-1:0];
      if (address == `OFS_IRQ_MASK)
        irq_mask_ff <= writedata[2:0];
    end
  end

  // ********************************************************************
  // Power state and read gate
  // ********************************************************************
  // Any write wakes the block; wake events alone never do.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      power_save_ff <= 1'b0;
      read_seen_ff <= 1'b0;
    end
    else if (soft_rst_ff)
    begin
      power_save_ff <= 1'b0;
      read_seen_ff <= 1'b0;
    end
    else if (power_save_ff)
    begin
      if (take_wr)
      begin
        power_save_ff <= 1'b0;
        read_seen_ff <= 1'b0;
      end
    end
    else
    begin
      if (take_rd)
        read_seen_ff <= 1'b1;
      if (wr_ok && address == `OFS_CTRL && writedata[`CTRL_POWER_SAVE])
        power_save_ff <= 1'b1;
    end
  end

  // ********************************************************************
  // Wake indicator
  // ********************************************************************
  // The request holds until a soft reset or a host write that wakes the block.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      wake_active_ff <= 1'b0;
    else if (soft_rst_ff || (power_save_ff && take_wr))
      wake_active_ff <= 1'b0;
    else if (wake_event && ctrl_ff[`CTRL_WAKE_EN])
      wake_active_ff <= 1'b1;
  end

  // Polarity and drive type of the wake pin.
  assign wake_level = wake_active_ff ~^ ctrl_ff[`CTRL_WAKE_POL];
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wake_indicator_out <= 1'b0;
      wake_indicator_oe_n <= 1'b1;
    end
    else if (ctrl_ff[`CTRL_WAKE_OD])
    begin
      wake_indicator_out <= 1'b0;
      wake_indicator_oe_n <= wake_level;
    end
    else
    begin
      wake_indicator_out <= wake_level;
      wake_indicator_oe_n <= 1'b0;
    end
  end

  // ********************************************************************
  // Interrupts
  // ********************************************************************
  // Sticky status; a new event wins over a same-cycle write-one clear.
  always @*
  begin
    irq_set[`IRQ_WAKE] = wake_event & ctrl_ff[`CTRL_WAKE_EN];
    irq_set[`IRQ_LINK] = link_up ^ link_prev_ff;
    irq_set[`IRQ_WOKE] = power_save_ff & take_wr;
    irq_clr = (wr_ok && address == `OFS_IRQ_STATUS) ? writedata[2:0] : 3'h0;
  end

  // Status register and link history.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_status_ff <= 3'h0;
      link_prev_ff <= 1'b0;
    end
    else if (soft_rst_ff)
    begin
      irq_status_ff <= 3'h0;
      link_prev_ff <= link_up;
    end
    else
    begin
      irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
      link_prev_ff <= link_up;
    end
  end

  assign irq = |(irq_status_ff & irq_mask_ff);

  // ********************************************************************
  // Crossover strap
  // ********************************************************************
  // The strap is sampled once on the first edge after reset release.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strap_taken_ff <= 1'b0;
      crossover_auto_enable <= 1'b1;
    end
    else if (!strap_taken_ff)
    begin
      strap_taken_ff <= 1'b1;
      crossover_auto_enable <= crossover_auto_strap;
    end
  end

  // ********************************************************************
  // Activity blink
  // ********************************************************************
  // Off for one interval, then on for at least one interval.
  always @*
  begin
    nxt_blink_state = blink_state_ff;
    nxt_blink_cnt = blink_cnt_ff;
    case (blink_state_ff)
      BL_IDLE:
      begin
        if (tx_rx_activity)
        begin
          nxt_blink_state = BL_OFF;
          nxt_blink_cnt = BLINK_CYCLES - 1'b1;
        end
      end
      BL_OFF:
      begin
        if (blink_cnt_ff == {`BLINK_CNT_W{1'b0}})
        begin
          nxt_blink_state = BL_HOLD;
          nxt_blink_cnt = BLINK_CYCLES - 1'b1;
        end
        else
          nxt_blink_cnt = blink_cnt_ff - 1'b1;
      end
      BL_HOLD:
      begin
        if (blink_cnt_ff == {`BLINK_CNT_W{1'b0}})
          nxt_blink_state = BL_IDLE;
        else
          nxt_blink_cnt = blink_cnt_ff - 1'b1;
      end
      default:
      begin
        nxt_blink_state = BL_IDLE;
        nxt_blink_cnt = {`BLINK_CNT_W{1'b0}};
      end
    endcase
  end

  // Blink state and interval counter.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      blink_state_ff <= BL_IDLE;
      blink_cnt_ff <= {`BLINK_CNT_W{1'b0}};
    end
    else if (soft_rst_ff)
    begin
      blink_state_ff <= BL_IDLE;
      blink_cnt_ff <= {`BLINK_CNT_W{1'b0}};
    end
    else
    begin
      blink_state_ff <= nxt_blink_state;
      blink_cnt_ff <= nxt_blink_cnt;
    end
  end

  // ********************************************************************
  // LED levels and pin drive
  // ********************************************************************
  // Active-low LED levels for speed, link/activity and duplex.
  always @*
  begin
    led_n[0] = link_up & speed_10 & ~autoneg_busy;
    led_n[1] = ~(link_up & (blink_state_ff != BL_OFF));
    led_n[2] = ~(link_up & full_duplex);
  end

  // Per-line drive: LED open-drain, then output type, else input.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gpio_out <= {`GPIO_N{1'b0}};
      gpio_oe_n <= {`GPIO_N{1'b1}};
    end
    else
    begin
      for (i = 0; i < `GPIO_N; i = i + 1)
      begin
        if (cfg_ff[`CFG_LED_LSB + i])
        begin
          gpio_out[i] <= 1'b0;
          gpio_oe_n[i] <= led_n[i];
        end
        else if (!cfg_ff[`CFG_DIR_LSB + i])
        begin
          gpio_out[i] <= 1'b0;
          gpio_oe_n[i] <= 1'b1;
        end
        else if (cfg_ff[`CFG_OD_LSB + i])
        begin
          gpio_out[i] <= 1'b0;
          gpio_oe_n[i] <= gpio_data_ff[i];
        end
        else
        begin
          gpio_out[i] <= gpio_data_ff[i];
          gpio_oe_n[i] <= 1'b0;
        end
      end
    end
  end

endmodule // status_led_wake_control

// file: dv/status_led_wake_control_props.sv
// Checker for the status LED and wake block, watching its top ports only.
// Assumes one clock with an active-high asynchronous reset.
`timescale 1ns/1ps
`include "status_led_wake_control_defs.vh"

module status_led_wake_control_props #(
  parameter [21:0] BLINK_CYCLES = 22'h00_0008
) (
  // Clock and reset.
  input wire clk,
  input wire reset,
  // Register bus.
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Strap, power state and wake pin.
  input wire crossover_auto_strap,
  input wire crossover_auto_enable,
  input wire power_save,
  input wire wake_indicator_out,
  input wire wake_indicator_oe_n
);
  // A write counts only on the edge where waitrequest is seen low.
  wire taken_wr = write && !waitrequest;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request waited more than one cycle");
  bus_idle_a: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high with no request");
  strap_load_a: assert property ($past(reset, 2) && !$past(reset) |->
    crossover_auto_enable == $past(crossover_auto_strap)) else $error("strap not loaded");
  strap_hold_a: assert property (!$past(reset, 2) && !$past(reset) |->
    $stable(crossover_auto_enable)) else $error("crossover enable moved outside reset");
  wake_exit_a: assert property (power_save && taken_wr |=> !power_save)
    else $error("write did not end power saving");
  sleep_keep_a: assert property (power_save && !taken_wr |=> power_save)
    else $error("power saving ended without a write");
  sleep_entry_a: assert property ($rose(power_save) |-> $past(taken_wr))
    else $error("power saving entered without a write");
  wake_drive_a: assert property (!(wake_indicator_out && wake_indicator_oe_n))
    else $error("wake pin drives high while released");
  byte_test_a: assert property (read && !waitrequest && address == `OFS_BYTE_TEST |->
    readdata == `BYTE_TEST_VALUE) else $error("byte test pattern wrong");

  // Main scenarios reached.
  cover property (power_save ##1 !power_save);
  cover property (read && !waitrequest && address == `OFS_BYTE_TEST);
  cover property ($fell(wake_indicator_oe_n));
endmodule // status_led_wake_control_props

// file: dv/led_pin_model.sv
// Pin-side model: LEDs to the supply on the three lines, plus the crossover strap.
// Assumes a released line is pulled high unless an outside driver takes it.
`timescale 1ns/1ps

module led_pin_model (
  // Drive from the block.
  input wire [2:0] out_val,
  input wire [2:0] oe_n,
  // Outside driver.
  input wire [2:0] ext_en,
  input wire [2:0] ext_val,
  input wire strap_low,
  // Levels seen on the pins.
  output wire [2:0] pin,
  output wire strap
);
  // A released line rests high through its LED unless driven from outside.
  assign pin = (~oe_n & out_val) | (oe_n & ext_en & ext_val) | (oe_n & ~ext_en);
  // The strap floats high through its pull-up unless held low.
  assign strap = ~strap_low;
endmodule // led_pin_model

// file: dv/test_status_led_wake_control.sv
// Self-checking bench for the status LED and wake block.
// Assumes the design, its defines header, checker and pin model compile first.
`timescale 1ns/1ps
`include "status_led_wake_control_defs.vh"

module test_status_led_wake_control;
  localparam int BLINK = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic link_up = 1'b0;
  logic speed_10 = 1'b0;
  logic autoneg_busy = 1'b0;
  logic full_duplex = 1'b0;
  logic tx_rx_activity = 1'b0;
  logic wake_event = 1'b0;
  logic strap_low = 1'b0;
  logic [2:0] ext_en = 3'h0;
  logic [2:0] ext_val = 3'h0;
  logic [31:0] rdv;
  wire [31:0] readdata;
  wire waitrequest, irq, strap, xover, power_save, wake_out, wake_oe_n;
  wire [2:0] pin, gpio_out, gpio_oe_n;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  status_led_wake_control #(.BLINK_CYCLES(22'(BLINK))) dut (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .link_up(link_up), .speed_10(speed_10), .autoneg_busy(autoneg_busy),
    .full_duplex(full_duplex), .tx_rx_activity(tx_rx_activity), .wake_event(wake_event),
    .crossover_auto_strap(strap), .crossover_auto_enable(xover), .power_save(power_save),
    .wake_indicator_out(wake_out), .wake_indicator_oe_n(wake_oe_n),
    .gpio_in(pin), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));

  led_pin_model u_pins (.out_val(gpio_out), .oe_n(gpio_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .strap_low(strap_low), .pin(pin), .strap(strap));

  // The clock toggles every half period of 12.5 ns.
  always #12.5 clk = ~clk;

  // A hang is cut short by a cycle ceiling.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      print_verdict;
    end
  end

  // ****************
  // Shared tasks
  // ****************
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Compares and counts; a mismatch is reported at once.
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_tests++;
      if (g !== e)
      begin
        mismatches++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // One bus cycle, held until waitrequest is seen low.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    begin
      write <= w;
      read <= !w;
      address <= a;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rdv = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
    end
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [4:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rdv, e);
    end
  endtask

  task pulse_wake;
    begin
      wake_event <= 1'b1;
      tick(1);
      wake_event <= 1'b0;
      tick(2);
    end
  endtask

  // Counts cycles the link/activity line keeps level v, up to 40.
  task run_len(input logic v, output int n);
    begin
      n = 0;
      while (gpio_oe_n[1] === v && n < 40)
      begin
        tick(1);
        n++;
      end
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  task s_first;
    begin
      wr(`OFS_IRQ_MASK, 32'h1);
      rd(`OFS_IRQ_MASK, 32'h0);
      wr(`OFS_IRQ_MASK, 32'h1);
      rd(`OFS_IRQ_MASK, 32'h1);
      rd(`OFS_BYTE_TEST, `BYTE_TEST_VALUE);
      rd(`OFS_STATE, 32'h5);
      rd(5'h1C, 32'h0);
    end
  endtask

  task s_gpio;
    begin
      wr(`OFS_GPIO_CFG, 32'h27);
      wr(`OFS_GPIO_DATA, 32'h5);
      rd(`OFS_GPIO_DATA, 32'h5);
      chk(32'(gpio_oe_n), 32'h0);
      wr(`OFS_GPIO_DATA, 32'h2);
      rd(`OFS_GPIO_DATA, 32'h2);
      chk(32'({gpio_out, gpio_oe_n}), 32'h2);
      ext_en <= 3'h7;
      ext_val <= 3'h3;
      wr(`OFS_GPIO_CFG, 32'h0);
      rd(`OFS_GPIO_DATA, 32'h3);
      ext_en <= 3'h0;
    end
  endtask

  task s_led;
    begin
      wr(`OFS_GPIO_CFG, 32'h700);
      link_up <= 1'b1;
      speed_10 <= 1'b1;
      full_duplex <= 1'b1;
      tick(2);
      chk(32'({gpio_out, gpio_oe_n}), 32'h1);
      autoneg_busy <= 1'b1;
      tick(2);
      chk(32'(gpio_oe_n), 32'h0);
      autoneg_busy <= 1'b0;
      speed_10 <= 1'b0;
      full_duplex <= 1'b0;
      tick(2);
      chk(32'(gpio_oe_n), 32'h4);
      link_up <= 1'b0;
      tick(2);
      chk(32'(gpio_oe_n), 32'h6);
    end
  endtask

  task s_blink;
    int h;
    int l;
    begin
      link_up <= 1'b1;
      tick(2);
      tx_rx_activity <= 1'b1;
      run_len(1'b0, l);
      run_len(1'b1, h);
      run_len(1'b0, l);
      chk(h, BLINK);
      chk(32'(l >= BLINK && l <= BLINK + 2), 32'h1);
      tx_rx_activity <= 1'b0;
      tick(2 * BLINK + 4);
      run_len(1'b0, l);
      chk(l, 40);
    end
  endtask

  task s_wake;
    begin
      wr(`OFS_CTRL, 32'h6);
      pulse_wake;
      chk(32'({wake_out, wake_oe_n, irq}), 32'h5);
      wr(`OFS_IRQ_STATUS, 32'h1);
      chk(32'(irq), 32'h0);
      wr(`OFS_CTRL, 32'h16);
      chk(32'(power_save), 32'h1);
      pulse_wake;
      chk(32'(power_save), 32'h1);
      wr(`OFS_BYTE_TEST, 32'h0);
      chk(32'(power_save), 32'h0);
      wr(`OFS_IRQ_MASK, 32'h0);
      rd(`OFS_IRQ_MASK, 32'h1);
      bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
      chk(rdv & 32'h4, 32'h4);
      wr(`OFS_CTRL, 32'hA);
      tick(1);
      chk(32'({wake_out, wake_oe_n}), 32'h1);
      pulse_wake;
      chk(32'({wake_out, wake_oe_n}), 32'h0);
    end
  endtask

  task s_soft;
    begin
      wr(`OFS_CTRL, 32'h1);
      tick(2);
      chk(32'(gpio_oe_n), 32'h7);
      wr(`OFS_IRQ_MASK, 32'h1);
      rd(`OFS_IRQ_MASK, 32'h0);
      rd(`OFS_GPIO_CFG, 32'h0);
    end
  endtask

  task s_hard;
    begin
      wr(`OFS_GPIO_CFG, 32'h7);
      reset <= 1'b1;
      strap_low <= 1'b1;
      tick(2);
      chk(32'({gpio_oe_n, power_save, xover}), 32'h1D);
      reset <= 1'b0;
      tick(3);
      chk(32'(xover), 32'h0);
      bus(1'b0, `OFS_STATE, 32'h0);
      chk(rdv & 32'h1, 32'h0);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Power-up reset for five cycles, then the scenarios in turn.
  initial
  begin
    tick(5);
    reset <= 1'b0;
    tick(1);
    s_first;
    s_gpio;
    s_led;
    s_blink;
    s_wake;
    s_soft;
    s_hard;
    print_verdict;
  end
endmodule // test_status_led_wake_control

bind status_led_wake_control status_led_wake_control_props #(.BLINK_CYCLES(BLINK_CYCLES))
  u_props (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest),
  .crossover_auto_strap(crossover_auto_strap),
  .crossover_auto_enable(crossover_auto_enable), .power_save(power_save),
  .wake_indicator_out(wake_indicator_out), .wake_indicator_oe_n(wake_indicator_oe_n));
